// ### core/hbmpc_pkg.sv
// package: constants and types of the bridge mode, protection and chopper logic
package hbmpc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEAD_TIME_NS = 40;
  localparam int DEAD_CYC_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYC = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
  localparam int OSC_PERIOD_NS = 100;
  localparam int OSC_CYC_RAW = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_CYC = (OSC_CYC_RAW < 1) ? 1 : OSC_CYC_RAW;
  localparam int OSC_PER_INT_CLK = 4;
  localparam int DISCHARGE_INT_CLKS = 39;
  localparam int ANALOG_DELAY_NS = 400;
  localparam int ANALOG_DELAY_RAW = ANALOG_DELAY_NS / CLK_PERIOD_NS;
  localparam int ANALOG_DELAY_CYC = (ANALOG_DELAY_RAW < 1) ? 1 : ANALOG_DELAY_RAW;
  localparam int TON_NS = 5350;
  localparam int TON_CYC = (TON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_NS = 1000000;
  localparam int TOFF_CYC = (TOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // leg drive codes {high side, low side}
  // ****************************************************************
  localparam logic [1:0] LEG_OFF = 2'h0;
  localparam logic [1:0] LEG_LOW = 2'h1;
  localparam logic [1:0] LEG_HIGH = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    HBMPC_NORMAL = 2'h0,
    HBMPC_THERMAL = 2'h1,
    HBMPC_OVERCUR = 2'h2
  } hbmpc_prot_t;

  typedef enum logic [1:0] {
    HBMPC_CHARGE = 2'h0,
    HBMPC_DISCHARGE = 2'h1,
    HBMPC_DELAY = 2'h2
  } hbmpc_chop_t;

  typedef struct packed {
    logic standby;
    logic dir_a;
    logic dir_b;
    logic pwm;
    logic stop_time_disable;
  } hbmpc_cmd_t;

  typedef struct packed {
    logic vm_uv;
    logic vcc_uv;
    logic over_temp;
    logic temp_ok;
    logic overcur;
    logic sense_over;
  } hbmpc_flags_t;

endpackage : hbmpc_pkg

// ### core/hbmpc_leg.sv
// module: one bridge leg with dead time between high and low side
`timescale 1ns/1ps
module hbmpc_leg #(
  parameter int DEAD = hbmpc_pkg::DEAD_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [1:0] target,
  output logic gate_hi,
  output logic gate_lo
);

  // ****************************************************************
  // dead time sequencing
  // ****************************************************************
  logic [7:0] dead_cnt;
  logic [1:0] cur;

  assign cur = {gate_hi, gate_lo};

  // a change away from an on side first goes through off, then waits out the dead time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
      dead_cnt <= 8'h00;
    end else if (target != cur && cur != hbmpc_pkg::LEG_OFF) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
      dead_cnt <= 8'(DEAD);
    end else if (target != cur && dead_cnt == 8'h00) begin
      gate_hi <= target[1];
      gate_lo <= target[0];
    end else if (dead_cnt != 8'h00) begin
      dead_cnt <= dead_cnt - 8'h01;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_LEG_NO_SHOOT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(gate_hi) |-> !gate_lo [*5])
    else $error("low side on within dead time after high side off");

  AST_LEG_NO_OVERLAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(gate_hi && gate_lo))
    else $error("both sides of a leg on");

  AST_LEG_FOLLOWS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (target == hbmpc_pkg::LEG_HIGH) [*8] |=> gate_hi && !gate_lo)
    else $error("leg did not follow a held high request");

endmodule : hbmpc_leg

// ### core/hbmpc_top.sv
// module: full-bridge mode decode, protection and peak-current chopper
// Functional notes
// - standby pin low or both directions low puts both outputs off
// - a alone drives a high, b alone drives b high, else short brake
// - standby clears latched thermal or overcurrent trips
// - fault pin pulled low only in normal operation
// - supply switch active low except in standby or undervoltage
// - motor supply undervoltage turns bridge off until flag clears
// - logic supply undervoltage releases every output until flag clears
// - over temperature enters thermal trip with bridge off
// - thermal trip ends when temperature recovered and stop time passed
// - stop time disabled keeps thermal trip until standby
// - overcurrent longer than detection time turns bridge off, fault high
// - overcurrent trip ends automatically after stop time
// - stop time disabled keeps overcurrent trip until standby
// - dead time inserted whenever a leg changes side
// - device handles mode change dead time, host inserts none
// - sense reaching the reference starts discharge as short brake
// - discharge lasts 39 internal clocks of four oscillator cycles plus delay
// - sense still above reference at the end restarts discharge
// - a begun discharge runs its full length unless normal operation ends
`timescale 1ns/1ps
module hbmpc_top #(
  parameter int TON_CYCLES = hbmpc_pkg::TON_CYC,
  parameter int TOFF_CYCLES = hbmpc_pkg::TOFF_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic standby_input,
  input wire logic direction_in_a,
  input wire logic direction_in_b,
  input wire logic speed_pwm_in,
  input wire logic stop_time_disable,
  input wire logic const_current_en,
  input wire logic vm_undervolt_flag,
  input wire logic vcc_undervolt_flag,
  input wire logic over_temp_flag,
  input wire logic temp_recovered_flag,
  input wire logic overcurrent_flag,
  input wire logic sense_over_ref_flag,
  output logic bridge_out_a_hi,
  output logic bridge_out_a_lo,
  output logic bridge_out_b_hi,
  output logic bridge_out_b_lo,
  output logic fault_out,
  output logic fault_oe,
  output logic supply_switch_out,
  output logic supply_switch_oe,
  output logic thermal_trip,
  output logic overcurrent_trip,
  output logic undervoltage_lock,
  output logic discharge_active
);

  localparam int TW = $clog2(TOFF_CYCLES + TON_CYCLES + 2);

  // ****************************************************************
  // input synchronizers
  // ****************************************************************
  hbmpc_pkg::hbmpc_cmd_t cmd_m;
  hbmpc_pkg::hbmpc_cmd_t cmd_s;
  hbmpc_pkg::hbmpc_flags_t flg_m;
  hbmpc_pkg::hbmpc_flags_t flg_s;

  // metastable stage read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_m <= '0;
      cmd_s <= '0;
      flg_m <= '0;
      flg_s <= '0;
    end else begin
      cmd_m <= '{standby_input, direction_in_a, direction_in_b, speed_pwm_in, stop_time_disable};
      flg_m <= '{vm_undervolt_flag, vcc_undervolt_flag, over_temp_flag,
                 temp_recovered_flag, overcurrent_flag, sense_over_ref_flag};
      cmd_s <= cmd_m;
      flg_s <= flg_m;
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  logic standby_mode;
  logic normal_op;
  logic brake_cmd;
  hbmpc_pkg::hbmpc_prot_t prot;
  hbmpc_pkg::hbmpc_chop_t chop;

  assign standby_mode = !cmd_s.standby || (!cmd_s.dir_a && !cmd_s.dir_b);
  assign normal_op = !standby_mode && prot == hbmpc_pkg::HBMPC_NORMAL
                     && !flg_s.vm_uv && !flg_s.vcc_uv;
  // either the pwm pin or the direction pins may carry the speed waveform
  assign brake_cmd = (cmd_s.dir_a && cmd_s.dir_b) || cmd_s.pwm;

  logic [1:0] tgt_a;
  logic [1:0] tgt_b;

  always_comb begin
    if (!normal_op) begin
      tgt_a = hbmpc_pkg::LEG_OFF;
      tgt_b = hbmpc_pkg::LEG_OFF;
    end else if (brake_cmd || chop != hbmpc_pkg::HBMPC_CHARGE) begin
      tgt_a = hbmpc_pkg::LEG_LOW;
      tgt_b = hbmpc_pkg::LEG_LOW;
    end else if (cmd_s.dir_a) begin
      tgt_a = hbmpc_pkg::LEG_HIGH;
      tgt_b = hbmpc_pkg::LEG_LOW;
    end else begin
      tgt_a = hbmpc_pkg::LEG_LOW;
      tgt_b = hbmpc_pkg::LEG_HIGH;
    end
  end

  // ****************************************************************
  // bridge legs
  // ****************************************************************
  hbmpc_leg #(.DEAD(hbmpc_pkg::DEAD_CYC)) u_leg_a (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .target(tgt_a),
    .gate_hi(bridge_out_a_hi),
    .gate_lo(bridge_out_a_lo)
  );

  hbmpc_leg #(.DEAD(hbmpc_pkg::DEAD_CYC)) u_leg_b (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .target(tgt_b),
    .gate_hi(bridge_out_b_hi),
    .gate_lo(bridge_out_b_lo)
  );

  // ****************************************************************
  // protection
  // ****************************************************************
  logic [TW-1:0] oc_cnt;
  logic [TW-1:0] stop_cnt;
  logic oc_detect;
  logic stop_done;

  assign oc_detect = oc_cnt >= TW'(TON_CYCLES);
  assign stop_done = stop_cnt >= TW'(TOFF_CYCLES);

  // overcurrent must persist for the detection time
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !flg_s.overcur || standby_mode) begin
      oc_cnt <= '0;
    end else if (!oc_detect) begin
      oc_cnt <= oc_cnt + TW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || prot == hbmpc_pkg::HBMPC_NORMAL) begin
      stop_cnt <= '0;
    end else if (!stop_done) begin
      stop_cnt <= stop_cnt + TW'(1);
    end
  end

  // thermal wins over overcurrent; standby clears both
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prot <= hbmpc_pkg::HBMPC_NORMAL;
    end else if (standby_mode) begin
      prot <= hbmpc_pkg::HBMPC_NORMAL;
    end else begin
      case (prot)
        hbmpc_pkg::HBMPC_NORMAL: begin
          if (flg_s.over_temp) begin
            prot <= hbmpc_pkg::HBMPC_THERMAL;
          end else if (oc_detect) begin
            prot <= hbmpc_pkg::HBMPC_OVERCUR;
          end
        end
        hbmpc_pkg::HBMPC_THERMAL: begin
          if (flg_s.temp_ok && stop_done && !cmd_s.stop_time_disable) begin
            prot <= hbmpc_pkg::HBMPC_NORMAL;
          end
        end
        hbmpc_pkg::HBMPC_OVERCUR: begin
          if (flg_s.over_temp) begin
            prot <= hbmpc_pkg::HBMPC_THERMAL;
          end else if (stop_done && !cmd_s.stop_time_disable) begin
            prot <= hbmpc_pkg::HBMPC_NORMAL;
          end
        end
        default: begin
          prot <= hbmpc_pkg::HBMPC_NORMAL;
        end
      endcase
    end
  end

  // ****************************************************************
  // reference oscillator and internal clock
  // ****************************************************************
  logic [7:0] osc_cnt;
  logic [1:0] int_cnt;
  logic osc_tick;
  logic int_tick;

  assign osc_tick = osc_cnt == 8'(hbmpc_pkg::OSC_CYC - 1);
  assign int_tick = osc_tick && int_cnt == 2'(hbmpc_pkg::OSC_PER_INT_CLK - 1);

  // free running so that the chopper timing never depends on drive state
  always_ff @(posedge sys_clk) begin
    if (sys_rst || osc_tick) begin
      osc_cnt <= 8'h00;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_cnt <= 2'h0;
    end else if (osc_tick) begin
      int_cnt <= int_cnt + 2'h1;
    end
  end

  // ****************************************************************
  // peak current chopper
  // ****************************************************************
  logic [7:0] dis_cnt;
  logic chop_run;

  assign chop_run = const_current_en && normal_op && !brake_cmd;

  // discharge starts at once, not on an internal clock edge, so the first period may be partial
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !normal_op) begin
      chop <= hbmpc_pkg::HBMPC_CHARGE;
      dis_cnt <= 8'h00;
    end else begin
      case (chop)
        hbmpc_pkg::HBMPC_CHARGE: begin
          dis_cnt <= 8'h00;
          if (chop_run && flg_s.sense_over) begin
            chop <= hbmpc_pkg::HBMPC_DISCHARGE;
          end
        end
        hbmpc_pkg::HBMPC_DISCHARGE: begin
          if (int_tick && dis_cnt == 8'(hbmpc_pkg::DISCHARGE_INT_CLKS - 1)) begin
            chop <= hbmpc_pkg::HBMPC_DELAY;
            dis_cnt <= 8'h00;
          end else if (int_tick) begin
            dis_cnt <= dis_cnt + 8'h01;
          end
        end
        hbmpc_pkg::HBMPC_DELAY: begin
          if (dis_cnt == 8'(hbmpc_pkg::ANALOG_DELAY_CYC - 1)) begin
            dis_cnt <= 8'h00;
            if (flg_s.sense_over && chop_run) begin
              chop <= hbmpc_pkg::HBMPC_DISCHARGE;
            end else begin
              chop <= hbmpc_pkg::HBMPC_CHARGE;
            end
          end else begin
            dis_cnt <= dis_cnt + 8'h01;
          end
        end
        default: begin
          chop <= hbmpc_pkg::HBMPC_CHARGE;
          dis_cnt <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // open-drain pins and status
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_out <= 1'b0;
      fault_oe <= 1'b0;
      supply_switch_out <= 1'b0;
      supply_switch_oe <= 1'b0;
    end else begin
      fault_out <= 1'b0;
      fault_oe <= normal_op;
      supply_switch_out <= 1'b0;
      supply_switch_oe <= !standby_mode && !flg_s.vm_uv && !flg_s.vcc_uv;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      thermal_trip <= 1'b0;
      overcurrent_trip <= 1'b0;
      undervoltage_lock <= 1'b0;
      discharge_active <= 1'b0;
    end else begin
      thermal_trip <= prot == hbmpc_pkg::HBMPC_THERMAL;
      overcurrent_trip <= prot == hbmpc_pkg::HBMPC_OVERCUR;
      undervoltage_lock <= flg_s.vm_uv || flg_s.vcc_uv;
      discharge_active <= chop != hbmpc_pkg::HBMPC_CHARGE;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [11:0] dis_len;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || chop == hbmpc_pkg::HBMPC_CHARGE || $rose(chop == hbmpc_pkg::HBMPC_DISCHARGE)) begin
      dis_len <= 12'h001;
    end else begin
      dis_len <= dis_len + 12'h001;
    end
  end

  AST_STANDBY_OFF: assert property (standby_mode |=> !bridge_out_a_hi && !bridge_out_a_lo
    && !bridge_out_b_hi && !bridge_out_b_lo)
    else $error("bridge not off in standby");
  AST_DECODE_FWD: assert property (normal_op && cmd_s.dir_a && !cmd_s.dir_b && !cmd_s.pwm
    && chop == hbmpc_pkg::HBMPC_CHARGE |-> tgt_a == hbmpc_pkg::LEG_HIGH && tgt_b == hbmpc_pkg::LEG_LOW)
    else $error("forward decode wrong");
  AST_BRAKE: assert property (normal_op && cmd_s.pwm |-> tgt_a == hbmpc_pkg::LEG_LOW
    && tgt_b == hbmpc_pkg::LEG_LOW)
    else $error("pwm high did not brake");
  AST_STANDBY_CLEARS: assert property (prot != hbmpc_pkg::HBMPC_NORMAL && standby_mode
    |=> prot == hbmpc_pkg::HBMPC_NORMAL)
    else $error("standby did not clear trip");
  AST_FAULT_PIN: assert property (normal_op |=> fault_oe)
    else $error("fault pin not low in normal operation");
  AST_FAULT_REL: assert property (!normal_op |=> !fault_oe)
    else $error("fault pin not released");
  AST_SUPPLY_SW: assert property (standby_mode || flg_s.vm_uv |=> !supply_switch_oe)
    else $error("supply switch active in standby or lockout");
  AST_UV_OFF: assert property (flg_s.vm_uv |=> !bridge_out_a_hi && !bridge_out_b_hi
    && !bridge_out_a_lo && !bridge_out_b_lo)
    else $error("bridge on during undervoltage");
  AST_THERMAL_IN: assert property (!standby_mode && flg_s.over_temp |=> prot == hbmpc_pkg::HBMPC_THERMAL)
    else $error("no thermal trip");
  AST_THERMAL_HOLD: assert property (prot == hbmpc_pkg::HBMPC_THERMAL && !standby_mode
    && (!flg_s.temp_ok || cmd_s.stop_time_disable || !stop_done) |=> prot == hbmpc_pkg::HBMPC_THERMAL)
    else $error("thermal trip left early");
  AST_OC_HOLD: assert property (prot == hbmpc_pkg::HBMPC_OVERCUR && !standby_mode &&
    !flg_s.over_temp && (cmd_s.stop_time_disable || !stop_done) |=> prot == hbmpc_pkg::HBMPC_OVERCUR)
    else $error("overcurrent trip left early");
  AST_OC_DETECT: assert property ($rose(prot == hbmpc_pkg::HBMPC_OVERCUR) |->
    $past(oc_cnt) >= TW'(TON_CYCLES))
    else $error("overcurrent trip before detection time");
  AST_DIS_LEN: assert property ($fell(chop == hbmpc_pkg::HBMPC_DELAY) && normal_op |->
    dis_len >= 12'(hbmpc_pkg::DISCHARGE_INT_CLKS * hbmpc_pkg::OSC_PER_INT_CLK * hbmpc_pkg::OSC_CYC))
    else $error("discharge period too short");
  AST_DIS_HOLD: assert property ($rose(chop == hbmpc_pkg::HBMPC_DISCHARGE) && normal_op
    |-> (chop == hbmpc_pkg::HBMPC_DISCHARGE || !normal_op) [*8])
    else $error("discharge cut short");

  COV_THERMAL_RECOVER: cover property (prot == hbmpc_pkg::HBMPC_THERMAL ##1 prot == hbmpc_pkg::HBMPC_NORMAL);
  COV_OC_TRIP: cover property ($rose(prot == hbmpc_pkg::HBMPC_OVERCUR));
  COV_RE_DISCHARGE: cover property (chop == hbmpc_pkg::HBMPC_DELAY ##1 chop == hbmpc_pkg::HBMPC_DISCHARGE);
  COV_REVERSE: cover property (bridge_out_b_hi && bridge_out_a_lo);

endmodule : hbmpc_top

// ### testbench/hbmpc_host_model.sv
// host controller model driving the mode, direction and speed pins
`timescale 1ns/1ps
module hbmpc_host_model (
  input wire logic sys_clk,
  input wire hbmpc_pkg::hbmpc_cmd_t cmd,
  input wire logic [1:0] pulse_mode,
  output logic standby_input,
  output logic direction_in_a,
  output logic direction_in_b,
  output logic speed_pwm_in,
  output logic stop_time_disable
);
  // ****************************************************************
  // pin drive, changed only at the falling edge
  // ****************************************************************
  logic [4:0] phase = 5'h00;

  // mode changes passed straight through, no off interval inserted
  always @(negedge sys_clk) begin
    phase <= phase + 5'h01;
    standby_input <= cmd.standby;
    stop_time_disable <= cmd.stop_time_disable;
    direction_in_a <= cmd.dir_a;
    // mode 2 chops through direction pin b, mode 1 through the speed pin
    direction_in_b <= cmd.dir_b | ((pulse_mode == 2'h2) & phase[4]);
    speed_pwm_in <= cmd.pwm | ((pulse_mode == 2'h1) & phase[4]);
  end
endmodule : hbmpc_host_model

// ### testbench/hbmpc_top_tb.sv
// testbench: directed tests of the bridge mode, protection and chopper logic
`timescale 1ns/1ps
module hbmpc_top_tb;
  // ****************************************************************
  // expected output words {a_hi,a_lo,b_hi,b_lo,fault_oe,sw_oe,thermal,oc,uv}
  // ****************************************************************
  localparam logic [8:0] e_standby = 9'h000;
  localparam logic [8:0] e_fwd = 9'h138;
  localparam logic [8:0] e_rev = 9'h0d8;
  localparam logic [8:0] e_brk = 9'h0b8;
  localparam logic [8:0] e_therm = 9'h00c;
  localparam logic [8:0] e_oc = 9'h00a;
  localparam logic [8:0] e_uv = 9'h001;
  localparam int per = hbmpc_pkg::OSC_CYC * hbmpc_pkg::OSC_PER_INT_CLK;
  // first internal clock may be partial, so one clock of slack
  localparam int dmin = per * (hbmpc_pkg::DISCHARGE_INT_CLKS - 1) + hbmpc_pkg::ANALOG_DELAY_CYC;
  localparam int dmax = per * hbmpc_pkg::DISCHARGE_INT_CLKS + hbmpc_pkg::ANALOG_DELAY_CYC + 3;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  hbmpc_pkg::hbmpc_cmd_t cmd = '0;
  hbmpc_pkg::hbmpc_flags_t flg = '0;
  logic [1:0] pmode = 2'h0;
  logic cc_en = 1'b0;
  logic standby_input, direction_in_a, direction_in_b, speed_pwm_in, stop_time_disable;
  logic a_hi, a_lo, b_hi, b_lo, fault_out, fault_oe, sw_out, sw_oe;
  logic thermal_trip, overcurrent_trip, undervoltage_lock, discharge_active;
  logic [8:0] outv;
  logic [1:0] hi_v, lo_v;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int run = 0;
  int last_len = 0;
  int hc, lc;
  int codes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 2, 4};
  int offc [2] = '{0, 0};
  logic last_hi [2] = '{1'b0, 1'b0};
  logic seen [2] = '{1'b0, 1'b0};

  always #4 sys_clk = ~sys_clk;
  assign outv = {a_hi, a_lo, b_hi, b_lo, fault_oe, sw_oe, thermal_trip, overcurrent_trip, undervoltage_lock};
  assign hi_v = {b_hi, a_hi};
  assign lo_v = {b_lo, a_lo};

  hbmpc_host_model u_hbmpc_host_model (.sys_clk(sys_clk), .cmd(cmd), .pulse_mode(pmode),
    .standby_input(standby_input), .direction_in_a(direction_in_a), .direction_in_b(direction_in_b),
    .speed_pwm_in(speed_pwm_in), .stop_time_disable(stop_time_disable));

  // short counts keep the protection timers inside the run
  hbmpc_top #(.TON_CYCLES(10), .TOFF_CYCLES(50)) u_hbmpc_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .standby_input(standby_input), .direction_in_a(direction_in_a), .direction_in_b(direction_in_b),
    .speed_pwm_in(speed_pwm_in), .stop_time_disable(stop_time_disable), .const_current_en(cc_en),
    .vm_undervolt_flag(flg.vm_uv), .vcc_undervolt_flag(flg.vcc_uv), .over_temp_flag(flg.over_temp),
    .temp_recovered_flag(flg.temp_ok), .overcurrent_flag(flg.overcur), .sense_over_ref_flag(flg.sense_over),
    .bridge_out_a_hi(a_hi), .bridge_out_a_lo(a_lo), .bridge_out_b_hi(b_hi), .bridge_out_b_lo(b_lo),
    .fault_out(fault_out), .fault_oe(fault_oe), .supply_switch_out(sw_out), .supply_switch_oe(sw_oe),
    .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
    .undervoltage_lock(undervoltage_lock), .discharge_active(discharge_active));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic fail(input string msg);
    errors++;
    $display("mismatch at time %0t: %s", $time, msg);
  endtask : fail

  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) fail(msg);
  endtask : check

  task automatic expect_out(input logic [8:0] e, input int lim, input string msg);
    int k = 0;
    while (outv !== e && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    check(outv === e, msg);
  endtask : expect_out

  task automatic hold_out(input logic [8:0] e, input int len, input string msg);
    int bad = 0;
    repeat (len) begin
      @(negedge sys_clk);
      if (outv !== e) bad++;
    end
    check(bad == 0, msg);
  endtask : hold_out

  task automatic set_cmd(input logic sb, input logic a, input logic b, input logic p, input logic dis);
    @(negedge sys_clk);
    cmd <= {sb, a, b, p, dis};
    repeat (4) @(negedge sys_clk);
  endtask : set_cmd

  // which: bit of the flag word, 3 over temperature, 1 overcurrent, 0 sense
  task automatic pulse_flag(input int which, input int len);
    @(negedge sys_clk);
    flg[which] <= 1'b1;
    repeat (len) @(negedge sys_clk);
    flg[which] <= 1'b0;
  endtask : pulse_flag

  task automatic wait_dis(input logic v, input int lim);
    int k = 0;
    while (discharge_active !== v && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
  endtask : wait_dis

  function automatic logic [8:0] dec(input logic a, input logic b, input logic p);
    if (!a && !b) return e_standby;
    if (p || (a && b)) return e_brk;
    return a ? e_fwd : e_rev;
  endfunction : dec

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // monitors and timeout
  // ****************************************************************
  always @(negedge sys_clk) begin
    if (!sys_rst && (fault_out !== 1'b0 || sw_out !== 1'b0)) fail("open-drain level");
    for (int i = 0; i < 2; i++) begin
      if (hi_v[i] === 1'b1 && lo_v[i] === 1'b1) begin
        fail("both gates of a leg on");
      end else if (hi_v[i] === 1'b1 || lo_v[i] === 1'b1) begin
        if (seen[i] && last_hi[i] !== hi_v[i] && offc[i] < hbmpc_pkg::DEAD_CYC) fail("dead time short");
        seen[i] = 1'b1;
        last_hi[i] = hi_v[i];
        offc[i] = 0;
      end else begin
        offc[i]++;
      end
    end
    if (discharge_active === 1'b1) begin
      run++;
    end else begin
      if (run > 0) last_len = run;
      run = 0;
    end
  end

  // whole run needs about 7000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      print_verdict();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst <= 1'b0;
    expect_out(e_standby, 0, "after reset");
    foreach (codes[j]) begin
      set_cmd(1'b1, codes[j][2], codes[j][1], codes[j][0], 1'b0);
      expect_out(dec(codes[j][2], codes[j][1], codes[j][0]), 30, "decode");
    end
    set_cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    expect_out(e_standby, 30, "standby pin");
    $display("test decode done");
    set_cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    for (int m = 1; m < 3; m++) begin
      hc = 0;
      lc = 0;
      pmode <= m[1:0];
      repeat (256) begin
        @(negedge sys_clk);
        if (a_hi === 1'b1) hc++;
        if (a_lo === 1'b1) lc++;
      end
      check(hc > 0 && lc > 0, "pulsed drive");
    end
    pmode <= 2'h0;
    expect_out(e_fwd, 30, "drive after pulsing");
    $display("test pulsed done");
    @(negedge sys_clk);
    flg.over_temp <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(thermal_trip === 1'b0, "flag not synchronized");
    expect_out(e_therm, 10, "thermal trip");
    @(negedge sys_clk);
    flg.over_temp <= 1'b0;
    hold_out(e_therm, 80, "thermal left while hot");
    @(negedge sys_clk);
    flg.temp_ok <= 1'b1;
    expect_out(e_fwd, 30, "thermal recovery");
    flg.temp_ok <= 1'b0;
    pulse_flag(3, 4);
    flg.temp_ok <= 1'b1;
    repeat (2) @(negedge sys_clk);
    hold_out(e_therm, 35, "thermal left before stop time");
    expect_out(e_fwd, 30, "thermal recovery after stop time");
    set_cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    pulse_flag(3, 4);
    expect_out(e_therm, 10, "latched thermal");
    hold_out(e_therm, 150, "thermal latch lost");
    set_cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    expect_out(e_standby, 10, "standby clears thermal");
    set_cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    expect_out(e_fwd, 30, "resume after standby");
    $display("test thermal done");
    pulse_flag(1, 8);
    hold_out(e_fwd, 30, "short overcurrent tripped");
    pulse_flag(1, 14);
    expect_out(e_oc, 10, "overcurrent trip");
    hold_out(e_oc, 25, "overcurrent left early");
    expect_out(e_fwd, 40, "overcurrent recovery");
    set_cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    pulse_flag(1, 14);
    expect_out(e_oc, 10, "latched overcurrent");
    hold_out(e_oc, 150, "overcurrent latch lost");
    pulse_flag(3, 4);
    expect_out(e_therm, 10, "trip escalation");
    set_cmd(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    expect_out(e_standby, 10, "direction standby clears trip");
    set_cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    expect_out(e_fwd, 30, "resume after trip clear");
    $display("test overcurrent done");
    for (int j = 0; j < 2; j++) begin
      {flg.vcc_uv, flg.vm_uv} <= 2'(j + 1);
      expect_out(e_uv, 10, "undervoltage lock");
      {flg.vcc_uv, flg.vm_uv} <= 2'h0;
      expect_out(e_fwd, 30, "undervoltage recovery");
    end
    $display("test undervoltage done");
    cc_en <= 1'b1;
    pulse_flag(0, 4);
    wait_dis(1'b1, 10);
    check(discharge_active === 1'b1, "discharge start");
    expect_out(e_brk, 20, "discharge brake");
    repeat (400) @(negedge sys_clk);
    pulse_flag(0, 3);
    wait_dis(1'b0, 2000);
    @(negedge sys_clk);
    check(last_len >= dmin && last_len <= dmax, "discharge length");
    expect_out(e_fwd, 30, "charge after discharge");
    flg.sense_over <= 1'b1;
    wait_dis(1'b1, 10);
    repeat (dmax + 10) @(negedge sys_clk);
    check(discharge_active === 1'b1, "repeated discharge");
    flg.sense_over <= 1'b0;
    wait_dis(1'b0, dmax);
    check(discharge_active === 1'b0, "repeated discharge end");
    expect_out(e_fwd, 30, "charge resumed");
    cc_en <= 1'b0;
    $display("test chopper done");
    print_verdict();
  end
endmodule : hbmpc_top_tb
